// ==== include/acmc_pkg.sv ====
// Package: constants for the ADC conversion-mode control block
package acmc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR  = 8'hd8; // Byte address of control
  localparam logic [7:0] CTRL_RESET = 8'h00; // Power-on value
  localparam logic [4:0] CTRL_BIT_BASE = 5'h1b; // Bit addresses d8..df

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DONE_BIT = 7; // Conversion done flag
  localparam int DMA_BIT  = 6; // DMA mode enable
  localparam int CONT_BIT = 5; // Continuous convert enable
  localparam int SNGL_BIT = 4; // Single convert trigger
  localparam int CHAN_MSB = 3; // Channel select field msb
  localparam int CHAN_LSB = 0; // Channel select field lsb

  // ---------------------------------------------------------------
  // Conversion timing: conversion length in ADC clocks, dividers in core clocks
  // ---------------------------------------------------------------
  localparam logic [4:0] CONV_CLKS = 5'h10; // Clocks after acquisition
  localparam logic [5:0] DIV_SEL0  = 6'h20; // Divider for select 00
  localparam logic [5:0] DIV_SEL1  = 6'h04; // Divider for select 01
  localparam logic [5:0] DIV_SEL2  = 6'h08; // Divider for select 10
  localparam logic [5:0] DIV_SEL3  = 6'h02; // Divider for select 11

  typedef enum logic [1:0] {ACMC_IDLE, ACMC_ACQ, ACMC_CONV} acmc_state_t;

endpackage

// ==== rtl/acmc_conv_seq.sv ====
// Conversion sequencer: divides the core clock and times one conversion
`timescale 1ns/1ps

module acmc_conv_seq (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [1:0] clk_div_sel,
  input  wire logic [1:0] acq_sel,
  output logic            busy,
  output logic            done
);

  // ---------------------------------------------------------------
  // Settings are latched at start so a mid-conversion change is safe
  // ---------------------------------------------------------------
  acmc_pkg::acmc_state_t state_reg;
  logic [5:0] div_reg;
  logic [5:0] div_cnt_reg;
  logic [4:0] clk_cnt_reg;
  logic       adc_tick;
  logic [5:0] div_next;

  // Divider ratio from the select code
  always_comb begin
    unique case (clk_div_sel)
      2'b00:   div_next = acmc_pkg::DIV_SEL0;
      2'b01:   div_next = acmc_pkg::DIV_SEL1;
      2'b10:   div_next = acmc_pkg::DIV_SEL2;
      default: div_next = acmc_pkg::DIV_SEL3;
    endcase
  end

  // One-cycle ADC clock enable, restarted with each conversion
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg     <= 6'h00;
      div_cnt_reg <= 6'h00;
    end else if (start && state_reg == acmc_pkg::ACMC_IDLE) begin
      div_reg     <= div_next;
      div_cnt_reg <= 6'h01;
    end else if (adc_tick) begin
      div_cnt_reg <= 6'h01;
    end else begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  assign adc_tick = (state_reg != acmc_pkg::ACMC_IDLE) &&
                    (div_cnt_reg == div_reg);

  // Acquisition then a fixed run of conversion clocks
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg   <= acmc_pkg::ACMC_IDLE;
      clk_cnt_reg <= 5'h00;
      done        <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        acmc_pkg::ACMC_IDLE: begin
          if (start) begin
            state_reg   <= acmc_pkg::ACMC_ACQ;
            clk_cnt_reg <= {3'b000, acq_sel} + 5'h01;
          end
        end
        acmc_pkg::ACMC_ACQ: begin
          if (adc_tick) begin
            if (clk_cnt_reg == 5'h01) begin
              state_reg   <= acmc_pkg::ACMC_CONV;
              clk_cnt_reg <= acmc_pkg::CONV_CLKS;
            end else begin
              clk_cnt_reg <= clk_cnt_reg - 5'h01;
            end
          end
        end
        acmc_pkg::ACMC_CONV: begin
          if (adc_tick) begin
            if (clk_cnt_reg == 5'h01) begin
              state_reg <= acmc_pkg::ACMC_IDLE;
              done      <= 1'b1;
            end else begin
              clk_cnt_reg <= clk_cnt_reg - 5'h01;
            end
          end
        end
      endcase
    end
  end

  assign busy = (state_reg != acmc_pkg::ACMC_IDLE);

endmodule // acmc_conv_seq

// ==== rtl/acmc_ctrl.sv ====
// Conversion control register with its hardware side effects
`timescale 1ns/1ps

//Function
// - The done flag in bit 7 sets when a single conversion or a DMA block finishes.
// - The done flag clears when the core vectors to the ADC handler, else software clears it.
// - Writing one to the DMA bit enables DMA, and the bit self-clears when the DMA cycle ends.
// - The address latch strobe stops while DMA is armed and runs again once DMA starts or ends.
// - With continuous mode set, a new conversion starts as soon as the last one completes.
// - The register sits at SFR address d8, resets to 00 and every bit is addressable.
// - The single convert bit clears itself when its conversion completes.
// - The channel comes from the select field, or from the stored identifier in DMA mode.
module acmc_ctrl (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wr,
  input  wire logic       bit_wdata,
  input  wire logic       vector_ack,
  input  wire logic       dma_active,
  input  wire logic       dma_conv_req,
  input  wire logic       dma_block_done,
  input  wire logic [3:0] dma_chan_id,
  input  wire logic [1:0] clk_div_sel,
  input  wire logic [1:0] acq_sel,
  input  wire logic       ale_in,
  output logic [7:0]      sfr_rdata,
  output logic [7:0]      ctrl_out,
  output logic            ale_out,
  output logic            conv_start,
  output logic            conv_done,
  output logic            conv_busy,
  output logic [3:0]      conv_chan
);

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  logic [7:0] adc_conversion_control_reg;
  logic [7:0] wr_val;
  logic       byte_hit;
  logic       bit_hit;
  logic       seq_busy;
  logic       seq_done;
  logic       start_now;
  logic       single_run_reg;

  assign byte_hit = sfr_wr && (sfr_addr == acmc_pkg::CTRL_ADDR);
  assign bit_hit  = bit_wr &&
                    (bit_addr[7:3] == acmc_pkg::CTRL_BIT_BASE);

  // Merge a byte write or a single bit write into one value
  always_comb begin
    wr_val = adc_conversion_control_reg;
    if (byte_hit) begin
      wr_val = sfr_wdata;
    end else if (bit_hit) begin
      wr_val[bit_addr[2:0]] = bit_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Conversion start
  // ---------------------------------------------------------------
  // Starts are only issued while the sequencer idles, so a trigger set
  // during a run waits rather than being dropped.
  logic arm_single;
  logic arm_cont;
  logic arm_dma;

  assign arm_single = adc_conversion_control_reg[acmc_pkg::SNGL_BIT] &&
                      !single_run_reg;
  assign arm_cont   = adc_conversion_control_reg[acmc_pkg::CONT_BIT];
  assign arm_dma    = adc_conversion_control_reg[acmc_pkg::DMA_BIT] &&
                      dma_conv_req;
  assign start_now  = !seq_busy && !conv_start &&
                      (arm_single || arm_cont || arm_dma);

  // Remember that the running conversion belongs to the single trigger
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      single_run_reg <= 1'b0;
    end else if (start_now) begin
      single_run_reg <= arm_single;
    end else if (seq_done) begin
      single_run_reg <= 1'b0;
    end
  end

  // Start pulse and the channel it samples
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_start <= 1'b0;
      conv_chan  <= 4'h0;
    end else begin
      conv_start <= start_now;
      if (start_now) begin
        if (adc_conversion_control_reg[acmc_pkg::DMA_BIT]) begin
          conv_chan <= dma_chan_id;
        end else begin
          conv_chan <= adc_conversion_control_reg[acmc_pkg::CHAN_MSB:
                                                  acmc_pkg::CHAN_LSB];
        end
      end
    end
  end

  acmc_conv_seq u_seq (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .start       (conv_start),
    .clk_div_sel (clk_div_sel),
    .acq_sel     (acq_sel),
    .busy        (seq_busy),
    .done        (seq_done)
  );

  // ---------------------------------------------------------------
  // Control register with hardware set and clear
  // ---------------------------------------------------------------
  // Hardware sets win over any clear in the same cycle.
  logic flag_set;
  logic flag_clr;

  assign flag_set = (seq_done && single_run_reg) ||
                    dma_block_done;
  assign flag_clr = vector_ack;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adc_conversion_control_reg <= acmc_pkg::CTRL_RESET;
    end else begin
      adc_conversion_control_reg <= wr_val;
      if (seq_done && single_run_reg) begin
        adc_conversion_control_reg[acmc_pkg::SNGL_BIT] <= 1'b0;
      end
      if (dma_block_done) begin
        adc_conversion_control_reg[acmc_pkg::DMA_BIT] <= 1'b0;
      end
      if (flag_set) begin
        adc_conversion_control_reg[acmc_pkg::DONE_BIT] <= 1'b1;
      end else if (flag_clr) begin
        adc_conversion_control_reg[acmc_pkg::DONE_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all registered
  // ---------------------------------------------------------------
  // Read data follows the address one cycle later; unmapped reads zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_addr == acmc_pkg::CTRL_ADDR) begin
      sfr_rdata <= adc_conversion_control_reg;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Strobe is held low only while DMA is armed but not yet running
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ale_out <= 1'b0;
    end else begin
      ale_out <= ale_in &&
                 !(adc_conversion_control_reg[acmc_pkg::DMA_BIT] &&
                   !dma_active);
    end
  end

  // Status copies for the rest of the ADC
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_out  <= acmc_pkg::CTRL_RESET;
      conv_done <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      ctrl_out  <= adc_conversion_control_reg;
      conv_done <= seq_done;
      conv_busy <= seq_busy || conv_start;
    end
  end

endmodule // acmc_ctrl

// ==== verif/acmc_ctrl_checker.sv ====
// Assertion checker for the conversion control register block
`timescale 1ns/1ps

module acmc_ctrl_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] bit_addr,
  input wire logic       bit_wr,
  input wire logic       bit_wdata,
  input wire logic       vector_ack,
  input wire logic       dma_active,
  input wire logic       dma_conv_req,
  input wire logic       dma_block_done,
  input wire logic [3:0] dma_chan_id,
  input wire logic [1:0] clk_div_sel,
  input wire logic [1:0] acq_sel,
  input wire logic       ale_in,
  input wire logic [7:0] sfr_rdata,
  input wire logic [7:0] ctrl_out,
  input wire logic       ale_out,
  input wire logic       conv_start,
  input wire logic       conv_done,
  input wire logic       conv_busy,
  input wire logic [3:0] conv_chan
);
  // ----------------------------------------------------------
  // Properties, all in the core clock domain
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Two edges of history needed: outputs are zero just after reset
  AST_ALE_GATE: assert property (
    !$past(rst) && !$past(rst, 2) |-> ale_out ==
    ($past(ale_in) && !(ctrl_out[6] && !$past(dma_active))))
    else $error("strobe gating wrong");
  AST_START_BUSY: assert property (
    conv_start |=> conv_busy) else $error("start without busy");
  AST_DMA_END: assert property (
    dma_block_done |-> ##2 (!ctrl_out[6] && ctrl_out[7]))
    else $error("dma end not seen");
  AST_VEC_CLR: assert property (
    vector_ack && !dma_block_done && !sfr_wr && !bit_wr ##1 !conv_done
    |-> ##1 !ctrl_out[7]) else $error("flag kept after vector");
  AST_SNGL_DONE: assert property (
    conv_done && ctrl_out[4] |=> ctrl_out[7] && !ctrl_out[4])
    else $error("single end wrong");
  AST_CONT_RUN: assert property (
    conv_done && ctrl_out[5] |-> ##[0:4] conv_start)
    else $error("no restart");
  AST_RD_ZERO: assert property (
    !$past(rst) && $past(sfr_addr) != acmc_pkg::CTRL_ADDR
    |-> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  AST_CHAN: assert property (
    conv_start && !ctrl_out[6] |-> conv_chan == ctrl_out[3:0])
    else $error("channel wrong");
endmodule // acmc_ctrl_checker

bind acmc_ctrl acmc_ctrl_checker u_chk (.clk_sys, .rst, .sfr_addr,
  .sfr_wr, .sfr_wdata, .bit_addr, .bit_wr, .bit_wdata, .vector_ack,
  .dma_active, .dma_conv_req, .dma_block_done, .dma_chan_id,
  .clk_div_sel, .acq_sel, .ale_in, .sfr_rdata, .ctrl_out, .ale_out,
  .conv_start, .conv_done, .conv_busy, .conv_chan);

// ==== verif/acmc_ctrl_bench.sv ====
// Self-checking bench for the conversion control register block
`timescale 1ns/1ps

module acmc_ctrl_bench;
  logic        clk_sys, rst = 1'b1, ale_in = 1'b0, bit_wdata = 1'b0;
  logic        sfr_wr = 1'b0, bit_wr = 1'b0, vector_ack = 1'b0;
  logic        dma_active = 1'b0, dma_conv_req = 1'b0, dma_block_done = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
  logic [3:0]  dma_chan_id = 4'h0, ch;
  logic [1:0]  clk_div_sel = 2'h3, acq_sel = 2'h0;
  logic [7:0]  sfr_rdata, ctrl_out;
  logic [3:0]  conv_chan;
  logic        ale_out, conv_start, conv_done, conv_busy;
  logic [31:0] seed = 32'h50b38395;
  int          num_errors = 0, total_checks = 0, exp_reg = 0, n;

  acmc_ctrl u_dut (.clk_sys, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
    .bit_addr, .bit_wr, .bit_wdata, .vector_ack, .dma_active,
    .dma_conv_req, .dma_block_done, .dma_chan_id, .clk_div_sel,
    .acq_sel, .ale_in, .sfr_rdata, .ctrl_out, .ale_out, .conv_start,
    .conv_done, .conv_busy, .conv_chan);

  // ----------------------------------------------------------
  // Clock, random source and helpers
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Random strobe so the gating is seen against real toggling
  always @(posedge clk_sys) ale_in <= ^rnd();

  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    sfr_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 cmp(sfr_rdata, a == acmc_pkg::CTRL_ADDR ? 8'(exp_reg) : 8'h00);
  endtask

  task automatic wr(logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= acmc_pkg::CTRL_ADDR;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    exp_reg = d;
  endtask

  task automatic bwr(logic [7:0] a, logic v);
    @(posedge clk_sys);
    bit_addr <= a;
    bit_wdata <= v;
    bit_wr <= 1'b1;
    @(posedge clk_sys);
    bit_wr <= 1'b0;
  endtask

  // Bounded wait; a missing event counts as a failed compare
  task automatic wait_for(ref logic s);
    n = 0;
    // Look 1 ns after the edge so a one-cycle pulse is seen settled
    do begin
      @(posedge clk_sys);
      #1;
    end while (s !== 1'b1 && ++n < 1000);
    cmp(8'(s), 8'h01);
  endtask

  task automatic final_report();
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(acmc_pkg::CTRL_ADDR);
    rd(8'h40);
    ch = 4'(rnd());
    clk_div_sel <= 2'(rnd());
    acq_sel <= 2'(rnd());
    wr({4'h1, ch});
    wait_for(conv_start);
    cmp(8'(conv_chan), 8'(ch));
    wait_for(conv_done);
    exp_reg = {4'h8, ch};
    rd(acmc_pkg::CTRL_ADDR);
    @(posedge clk_sys);
    vector_ack <= 1'b1;
    @(posedge clk_sys);
    vector_ack <= 1'b0;
    exp_reg = ch;
    rd(acmc_pkg::CTRL_ADDR);
    bwr(8'hde, 1'b1);
    exp_reg = exp_reg | 8'h40;
    rd(acmc_pkg::CTRL_ADDR);
    repeat (4) begin
      @(posedge clk_sys);
      #1 cmp(8'(ale_out), 8'h00);
    end
    dma_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    dma_block_done <= 1'b1;
    @(posedge clk_sys);
    dma_block_done <= 1'b0;
    dma_active <= 1'b0;
    exp_reg = (exp_reg & 8'hbf) | 8'h80;
    rd(acmc_pkg::CTRL_ADDR);
    bwr(8'hdf, 1'b0);
    exp_reg = exp_reg & 8'h7f;
    rd(acmc_pkg::CTRL_ADDR);
    wr({4'h2, ch});
    repeat (3) wait_for(conv_start);
    wr(8'h00);
    rd(acmc_pkg::CTRL_ADDR);
    final_report();
  end

  // Watchdog well beyond the longest conversion chain
  initial begin
    #150000;
    num_errors++;
    final_report();
  end
endmodule // acmc_ctrl_bench
